// [shared/smt_pkg.sv]
// Constants shared by the supply min/max tracker and its core
package smt_pkg;

  // ==========================================================
  // Widths
  localparam int RES_W    = 12;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 8;
  localparam int MV_W     = 16;
  localparam int SCALE_SH = 16;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_MIN_HI = 8'h1D;
  localparam logic [ADDR_W-1:0] OFS_MIN_LO = 8'h1E;
  localparam logic [ADDR_W-1:0] OFS_MAX_HI = 8'h1F;
  localparam logic [ADDR_W-1:0] OFS_MAX_LO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h31;

  // ==========================================================
  // Field positions
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STAT_SRC_BIT   = 0;
  localparam int STAT_SEEN_BIT  = 1;
  localparam int LO_W           = 8;

  // ==========================================================
  // Reset, clear and saturation values
  localparam logic [DATA_W-1:0] RST_RESULT = 8'h00;
  localparam logic              RST_MODE   = 1'b0;
  localparam logic [RES_W-1:0]  FULL_SCALE = 12'hFFF;
  localparam logic [RES_W-1:0]  ZERO_SCALE = 12'h000;

  // ==========================================================
  // Encoding: one count in microvolts, and Q16 reciprocal multipliers
  localparam int LSB_UV_MAIN = 1490;
  localparam int LSB_UV_AUX  = 1010;
  localparam int UV_PER_MV   = 1000;
  localparam int MULT_MAIN   = ((1 << SCALE_SH) * UV_PER_MV + LSB_UV_MAIN / 2) / LSB_UV_MAIN;
  localparam int MULT_AUX    = ((1 << SCALE_SH) * UV_PER_MV + LSB_UV_AUX / 2) / LSB_UV_AUX;

endpackage

// [shared/smt_if.sv]
// Carrier between the register front end and the min/max core
`timescale 1ns/100ps
interface smt_if #(parameter int W = 12);
  logic [W-1:0] sample;
  logic         valid;
  logic         clear;
  logic         inhibit_min;
  logic         inhibit_max;
  logic [W-1:0] min_val;
  logic [W-1:0] max_val;

  modport ctl (output sample, valid, clear, inhibit_min, inhibit_max,
               input  min_val, max_val);
  modport trk (input  sample, valid, clear, inhibit_min, inhibit_max,
               output min_val, max_val);
endinterface

// [hdl/smt_core.sv]
// Minimum and maximum trackers for the encoded supply voltage
`timescale 1ns/100ps
module smt_core
  import smt_pkg::*;
#(
  parameter int W = 12
)
(
  input wire logic clk,
  input wire logic rst_n,
  smt_if.trk       tif
);

  // ==========================================================
  // Elaboration check
  if (W != RES_W)
  begin : g_bad_width
    $error("smt_core: tracker width must match the 12-bit result");
  end

  logic [W-1:0] min_r;
  logic [W-1:0] max_r;
  logic         arm_min_r;
  logic         arm_max_r;
  logic         upd_min;
  logic         upd_max;

  assign upd_min = tif.valid && !tif.inhibit_min && (arm_min_r || tif.sample < min_r);
  assign upd_max = tif.valid && !tif.inhibit_max && (arm_max_r || tif.sample > max_r);

  // ==========================================================
  // Minimum tracker
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      min_r     <= '0;
      arm_min_r <= 1'b1;
    end
    else if (tif.clear && tif.valid && !tif.inhibit_min)
    begin
      min_r     <= tif.sample;
      arm_min_r <= 1'b0;
    end
    else if (tif.clear)
    begin
      min_r     <= FULL_SCALE[W-1:0];
      arm_min_r <= 1'b0;
    end
    else if (upd_min)
    begin
      min_r     <= tif.sample;
      arm_min_r <= 1'b0;
    end
  end

  // ==========================================================
  // Maximum tracker
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      max_r     <= '0;
      arm_max_r <= 1'b1;
    end
    else if (tif.clear && tif.valid && !tif.inhibit_max)
    begin
      max_r     <= tif.sample;
      arm_max_r <= 1'b0;
    end
    else if (tif.clear)
    begin
      max_r     <= ZERO_SCALE[W-1:0];
      arm_max_r <= 1'b0;
    end
    else if (upd_max)
    begin
      max_r     <= tif.sample;
      arm_max_r <= 1'b0;
    end
  end

  assign tif.min_val = min_r;
  assign tif.max_val = max_r;

  // ==========================================================
  // Checks
  a_min_lower_taken: assert property (@(posedge clk) disable iff (!rst_n)
    tif.valid && !tif.inhibit_min && !tif.clear && tif.sample < min_r
    |=> min_r == $past(tif.sample))
    else $error("lower sample not taken as minimum");

  a_max_higher_taken: assert property (@(posedge clk) disable iff (!rst_n)
    tif.valid && !tif.inhibit_max && !tif.clear && tif.sample > max_r
    |=> max_r == $past(tif.sample))
    else $error("higher sample not taken as maximum");

  a_clear_extremes: assert property (@(posedge clk) disable iff (!rst_n)
    tif.clear && !tif.valid
    |=> min_r == FULL_SCALE[W-1:0] && max_r == ZERO_SCALE[W-1:0])
    else $error("clear did not load full scale and zero");

  a_min_never_rises: assert property (@(posedge clk) disable iff (!rst_n)
    !tif.clear && !arm_min_r |=> min_r <= $past(min_r))
    else $error("minimum rose without a clear");

endmodule // smt_core

// [hdl/smt_top.sv]
// Supply voltage min/max tracker with coherent two-register reads
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - High register bits 3:0 hold result bits 11:8; bits 7:4 read zero.
// - Low register bits 7:0 hold result bits 7:0.
// - Minimum replaced by any lower measurement since the last clear.
// - Maximum replaced by any higher measurement since the last clear.
// - Mode bit 1 measures the auxiliary supply, else the main battery.
// - Addressing a result register freezes updates to that tracker.
// - Reading a high register copies its live low byte into a shadow.
// - Reading a low register returns its shadow, not the live value.
// - Main battery results count 1.49 mV per step.
// - Auxiliary supply results count 1.01 mV per step.
module smt_top
  import smt_pkg::*;
#(
  parameter int RES_WIDTH = RES_W
)
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              meas_valid,
  input  wire logic [MV_W-1:0]   main_mv,
  input  wire logic [MV_W-1:0]   aux_mv,
  output logic                   source_is_aux
);

  // ==========================================================
  // Elaboration check
  if (RES_WIDTH != RES_W)
  begin : g_bad_width
    $error("smt_top: result width must match the 12-bit register layout");
  end

  localparam int PROD_W = MV_W + SCALE_SH + 1;
  localparam logic [SCALE_SH:0] MULT_MAIN_C = MULT_MAIN[SCALE_SH:0];
  localparam logic [SCALE_SH:0] MULT_AUX_C  = MULT_AUX[SCALE_SH:0];

  // ==========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_n_s;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  // ==========================================================
  // Control register
  logic mode_r;
  logic clear_r;
  logic seen_r;
  logic wr_ctrl;

  assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      mode_r <= RST_MODE;
    else if (wr_ctrl)
      mode_r <= reg_wdata[CTRL_MODE_BIT];
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      clear_r <= 1'b0;
    else
      clear_r <= wr_ctrl && reg_wdata[CTRL_CLEAR_BIT];
  end

  assign source_is_aux = mode_r;

  // ==========================================================
  // Source selection and encoding
  logic [MV_W-1:0]     mv_sel;
  logic [SCALE_SH:0]   mult_sel;
  logic [PROD_W-1:0]   prod;
  logic [PROD_W-SCALE_SH-1:0] quot;
  logic [RES_W-1:0]    enc_nxt;
  logic [RES_W-1:0]    enc_r;
  logic                enc_vld_r;

  always_comb
  begin
    mv_sel   = mode_r ? aux_mv : main_mv;
    mult_sel = mode_r ? MULT_AUX_C : MULT_MAIN_C;
    prod     = mv_sel * mult_sel;
    quot     = prod[PROD_W-1:SCALE_SH];
    if (quot > {{(PROD_W-SCALE_SH-RES_W){1'b0}}, FULL_SCALE})
      enc_nxt = FULL_SCALE;
    else
      enc_nxt = quot[RES_W-1:0];
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      enc_r     <= ZERO_SCALE;
      enc_vld_r <= 1'b0;
    end
    else
    begin
      enc_vld_r <= meas_valid;
      if (meas_valid)
        enc_r <= enc_nxt;
    end
  end

  // ==========================================================
  // Trackers
  smt_if #(.W(RES_W)) tif ();

  logic min_addressed;
  logic max_addressed;

  assign min_addressed   = reg_addr == OFS_MIN_HI || reg_addr == OFS_MIN_LO;
  assign max_addressed   = reg_addr == OFS_MAX_HI || reg_addr == OFS_MAX_LO;
  assign tif.sample      = enc_r;
  assign tif.valid       = enc_vld_r;
  assign tif.clear       = clear_r;
  assign tif.inhibit_min = min_addressed;
  assign tif.inhibit_max = max_addressed;

  smt_core #(.W(RES_W)) u_core (
    .clk   (mclk),
    .rst_n (rst_n_s),
    .tif   (tif)
  );

  // Seen flag: a sample in the clear cycle wins over the clear
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      seen_r <= 1'b0;
    else if (enc_vld_r)
      seen_r <= 1'b1;
    else if (clear_r)
      seen_r <= 1'b0;
  end

  // ==========================================================
  // Low-byte shadows
  logic [LO_W-1:0] min_lo_shadow_r;
  logic [LO_W-1:0] max_lo_shadow_r;
  logic            rd_min_hi;
  logic            rd_max_hi;

  assign rd_min_hi = reg_rd && reg_addr == OFS_MIN_HI;
  assign rd_max_hi = reg_rd && reg_addr == OFS_MAX_HI;

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      min_lo_shadow_r <= RST_RESULT;
    else if (rd_min_hi)
      min_lo_shadow_r <= tif.min_val[LO_W-1:0];
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      max_lo_shadow_r <= RST_RESULT;
    else if (rd_max_hi)
      max_lo_shadow_r <= tif.max_val[LO_W-1:0];
  end

  // ==========================================================
  // Read port
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_r;

  always_comb
  begin
    rd_mux = RST_RESULT;
    case (reg_addr)
      OFS_MIN_HI: rd_mux = {4'h0, tif.min_val[RES_W-1:LO_W]};
      OFS_MIN_LO: rd_mux = min_lo_shadow_r;
      OFS_MAX_HI: rd_mux = {4'h0, tif.max_val[RES_W-1:LO_W]};
      OFS_MAX_LO: rd_mux = max_lo_shadow_r;
      OFS_CTRL:   rd_mux = {7'h00, mode_r};
      OFS_STAT:   rd_mux = {6'h00, seen_r, mode_r};
      default:    rd_mux = RST_RESULT;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      rdata_r <= RST_RESULT;
    else if (reg_rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= RST_RESULT;
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_s);

  logic [31:0]     chk_uv;
  logic [31:0]     chk_lsb;
  logic [31:0]     chk_lo;
  logic [MV_W-1:0] chk_mv_r;
  logic            chk_mode_r;

  // Source and mode as taken at the previous clock edge
  always_ff @(posedge mclk)
  begin
    chk_mv_r   <= mv_sel;
    chk_mode_r <= mode_r;
  end

  assign chk_uv  = {16'h0000, chk_mv_r} * 32'(UV_PER_MV);
  assign chk_lsb = chk_mode_r ? 32'(LSB_UV_AUX) : 32'(LSB_UV_MAIN);
  assign chk_lo  = {20'h00000, enc_r} * chk_lsb;

  a_hi_nibble_read: assert property (
    reg_rd && reg_addr == OFS_MIN_HI
    |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(tif.min_val[11:8]))
    else $error("high register read wrong");

  a_shadow_capture: assert property (
    reg_rd && reg_addr == OFS_MAX_HI
    |=> max_lo_shadow_r == $past(tif.max_val[7:0]))
    else $error("shadow not loaded on high read");

  a_lo_from_shadow: assert property (
    reg_rd && reg_addr == OFS_MIN_LO |=> reg_rdata == $past(min_lo_shadow_r))
    else $error("low read did not return shadow");

  a_coherent_pair: assert property (
    reg_rd && reg_addr == OFS_MIN_HI ##1 reg_rd && reg_addr == OFS_MIN_LO
    |=> {$past(reg_rdata[3:0]), reg_rdata} == $past(tif.min_val, 2))
    else $error("high and low reads not coherent");

  a_addressed_frozen: assert property (
    min_addressed && !clear_r |=> $stable(tif.min_val))
    else $error("minimum changed while addressed");

  a_source_select: assert property (
    meas_valid |=> $past(mv_sel) == ($past(mode_r) ? $past(aux_mv) : $past(main_mv)))
    else $error("wrong supply measured");

  a_main_scale: assert property (
    meas_valid && !mode_r && main_mv < 16'd6000
    |=> chk_lo <= chk_uv + chk_lsb && chk_uv < chk_lo + 32'd2 * chk_lsb)
    else $error("main battery count not 1.49 mV");

  a_aux_scale: assert property (
    meas_valid && mode_r && aux_mv < 16'd4000
    |=> chk_lo <= chk_uv + chk_lsb && chk_uv < chk_lo + 32'd2 * chk_lsb)
    else $error("auxiliary count not 1.01 mV");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");

  a_max_hi_nibble: assert property (
    reg_rd && reg_addr == OFS_MAX_HI
    |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(tif.max_val[11:8]))
    else $error("maximum high register read wrong");

  a_min_shadow_load: assert property (
    rd_min_hi |=> min_lo_shadow_r == $past(tif.min_val[7:0]))
    else $error("minimum shadow not loaded on high read");

  a_max_lo_shadow: assert property (
    reg_rd && reg_addr == OFS_MAX_LO |=> reg_rdata == $past(max_lo_shadow_r))
    else $error("maximum low read did not return shadow");

  a_max_frozen: assert property (
    max_addressed && !clear_r |=> $stable(tif.max_val))
    else $error("maximum changed while addressed");

  a_mode_write: assert property (
    wr_ctrl |=> source_is_aux == $past(reg_wdata[CTRL_MODE_BIT]))
    else $error("mode bit not taken from write");

  a_clear_pulse: assert property (
    wr_ctrl && reg_wdata[CTRL_CLEAR_BIT] |=> clear_r)
    else $error("clear write did not raise clear");

  c_clear_then_sample: cover property (clear_r ##[1:20] enc_vld_r);
  c_read_pair: cover property (rd_min_hi ##1 reg_rd && reg_addr == OFS_MIN_LO);
  c_inhibited_sample: cover property (enc_vld_r && max_addressed);
  c_aux_mode: cover property (mode_r && enc_vld_r);

endmodule // smt_top

// [testbench/tb.sv]
// Self-checking bench for the supply min/max tracker
`timescale 1ns/100ps
module tb
  import smt_pkg::*;
;
  logic              mclk;
  logic              rstn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              meas_valid;
  logic [MV_W-1:0]   main_mv;
  logic [MV_W-1:0]   aux_mv;
  logic              source_is_aux;
  int                err_total;
  int                compares;
  int                min_m;
  int                max_m;
  bit                armed;
  bit                aux_m;

  smt_top u_dut (
    .mclk          (mclk),
    .rstn          (rstn),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .meas_valid    (meas_valid),
    .main_mv       (main_mv),
    .aux_mv        (aux_mv),
    .source_is_aux (source_is_aux)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    test_done();
  end

  // ==========================================================
  // Register bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= 8'h00;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= 8'h00;
    #1 d = reg_rdata;
  endtask

  task automatic rdpair(input logic [7:0] hi, output logic [11:0] v);
    logic [7:0] h;
    logic [7:0] l;
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= hi;
    @(posedge mclk);
    reg_addr <= hi + 8'h01;
    #1 h = reg_rdata;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= 8'h00;
    #1 l = reg_rdata;
    chk({8'h00, h[7:4]}, 12'h000, "reserved high bits");
    v = {h[3:0], l};
  endtask

  task automatic check_all;
    logic [11:0] v;
    rdpair(OFS_MIN_HI, v);
    chk(v, min_m[11:0], "minimum");
    rdpair(OFS_MAX_HI, v);
    chk(v, max_m[11:0], "maximum");
  endtask

  // ==========================================================
  // Measurement stimulus and model
  function automatic int enc(input int mv);
    longint c;
    c = (longint'(mv) * (aux_m ? MULT_AUX : MULT_MAIN)) >>> SCALE_SH;
    return (c > 4095) ? 4095 : int'(c);
  endfunction

  task automatic samp(input int mv, input logic [7:0] ia);
    int          c;
    logic [15:0] o;
    c = enc(mv);
    o = 16'($urandom_range(8000));
    @(posedge mclk);
    meas_valid <= 1'b1;
    main_mv    <= aux_m ? o : mv[15:0];
    aux_mv     <= aux_m ? mv[15:0] : o;
    reg_addr   <= ia;
    @(posedge mclk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge mclk);
    reg_addr   <= 8'h00;
    if (!armed)
    begin
      min_m = c;
      max_m = c;
      armed = 1'b1;
    end
    else
    begin
      if (ia != OFS_MIN_HI && ia != OFS_MIN_LO && c < min_m) min_m = c;
      if (ia != OFS_MAX_HI && ia != OFS_MAX_LO && c > max_m) max_m = c;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] d;
    logic [7:0] l;
    int         prev_lo;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    meas_valid = 1'b0;
    main_mv = 16'h0000;
    aux_mv = 16'h0000;
    err_total = 0;
    compares = 0;
    min_m = 0;
    max_m = 0;
    armed = 1'b0;
    aux_m = 1'b0;
    void'($urandom(32'hA1C5));
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(OFS_MIN_LO, d);
    chk({4'h0, d}, 12'h000, "shadow after reset");
    check_all();
    chk({11'h0, source_is_aux}, 12'h000, "source after reset");
    rd(8'h05, d);
    chk({4'h0, d}, 12'h000, "unmapped read");
    $display("test reset values done");

    for (int i = 0; i < 12; i++)
    begin
      samp((i == 3) ? 0 : (i == 5) ? 7000 : int'($urandom_range(7000)), 8'h00);
      check_all();
    end
    $display("test main battery done");

    wr(OFS_CTRL, 8'h01);
    #1 chk({11'h0, source_is_aux}, 12'h001, "source select");
    aux_m = 1'b1;
    rd(OFS_CTRL, d);
    chk({4'h0, d}, 12'h001, "mode readback");
    wr(OFS_MIN_HI, 8'h0F);
    for (int i = 0; i < 8; i++)
    begin
      samp(int'($urandom_range(5000)), 8'h00);
      check_all();
    end
    rd(OFS_STAT, d);
    chk({4'h0, d}, 12'h003, "status after samples");
    $display("test auxiliary supply done");

    wr(OFS_CTRL, 8'h03);
    min_m = 4095;
    max_m = 0;
    check_all();
    rd(OFS_STAT, d);
    chk({4'h0, d}, 12'h001, "status after clear");
    rd(OFS_CTRL, d);
    chk({4'h0, d}, 12'h001, "clear bit reads zero");
    samp(3000, 8'h00);
    check_all();
    rd(OFS_STAT, d);
    chk({4'h0, d}, 12'h003, "status after first sample");
    $display("test clear done");

    prev_lo = min_m & 8'hFF;
    rd(OFS_MIN_HI, d);
    samp(1000, 8'h00);
    rd(OFS_MIN_LO, l);
    chk({4'h0, l}, prev_lo[11:0], "shadow holds old low byte");
    check_all();
    $display("test shadow done");

    samp(100, OFS_MIN_LO);
    check_all();
    samp(4800, OFS_MAX_HI);
    check_all();
    samp(50, OFS_MIN_HI);
    samp(4900, OFS_MAX_LO);
    check_all();
    $display("test update freeze done");
    test_done();
  end
endmodule // tb
